/* File: npic_top.sv */
/*
 * Nested priority interrupt controller: pending latches, two-step
 * arbitration, stacking and vector fetch sequencer, current priority
 * bits, wake-up requests and an APB register slave.
 * Assumes the core pushes one stack byte per o_push pulse, fetches the
 * vector on o_vec_fetch and signals instruction boundaries itself.
 */
// Decided for this implementation: the placing of the registers and register access over APB.
// Functional notes
// RULE_01 - Four levels in two current priority bits
// RULE_02 - Service: stack PC X A CC, load priority
// RULE_03 - Return restores popped priority bits
// RULE_04 - Highest software level wins, then hardware order
// RULE_05 - Unserviced request stays latched pending
// RULE_06 - Reset, trap, emergency stop count highest
// RULE_07 - Non-maskables ignore level, end at level 3
// RULE_08 - Non-maskables wake the core from halt; the code wakes on trap only, emergency stop is not in HALT_CAP
// RULE_09 - Trap is handled like emergency stop
// RULE_10 - Reset starts at level 3, reset vector
// RULE_11 - Maskable needs enable and level above current
// RULE_12 - Emergency stop from pin edge or speed error
// RULE_13 - External lines wake halt, sensitivity programmable
// RULE_14 - Edge latch clears on service entry
// RULE_15 - Selected pins of a line are ORed
// RULE_16 - Peripheral request is flag and enable
// RULE_17 - Clearing sequence discards the pending latch
// RULE_18 - Sixteen vectors from ffe0 to ffff
// RULE_19 - Hardware order: groups rising, stop highest
// RULE_20 - Level 0 writes to priority fields ignored
// RULE_21 - Any pending source wakes from wait
// RULE_22 - Pending held until serviced, cleared on reset
module npic_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_instr_done,
    input wire logic i_trap,
    input wire logic i_return_from_interrupt,
    input wire logic [1:0] i_pop_prio,
    input wire logic i_prio_wr,
    input wire logic [1:0] i_prio_wdata,
    input wire logic i_halt,
    input wire logic [15:0] i_ext_pin,
    input wire logic i_motor_emergency_stop_pin,
    input wire logic i_speed_err,
    input wire logic [13:0] i_periph_flag,
    input wire logic [13:0] i_periph_en,
    input wire logic [13:0] i_periph_clr,
    output logic o_push,
    output logic [2:0] o_push_item,
    output logic o_vec_fetch,
    output logic [15:0] o_vec_addr,
    output logic [1:0] o_prio,
    output logic o_wake_halt,
    output logic o_wake_wait
);

    npic_pkg::npic_regs_t r;
    npic_pkg::npic_regs_t n;
    logic [npic_pkg::NGRP-1:0] ext_evt;
    logic [npic_pkg::NGRP-1:0] ext_lvl;
    logic [npic_pkg::NVEC-1:0] ent;
    logic found;
    logic [3:0] best;
    logic wr_ok;

    always_comb begin
        logic [15:0] rise;
        logic [15:0] fall;
        logic [1:0] m;
        logic [1:0] f;
        logic [2:0] lv;
        logic [2:0] best_lv;
        logic [2:0] cur;
        logic [13:0] preq;
        logic motor_emergency_stop_evt;
        logic ok;
        int g;
        int v;
        int idx;
        rise = '0;
        fall = '0;
        m = '0;
        f = '0;
        lv = '0;
        best_lv = '0;
        cur = '0;
        preq = '0;
        motor_emergency_stop_evt = 1'b0;
        ok = 1'b0;
        g = 0;
        v = 0;
        idx = 0;
        n = r;
        n.push = 1'b0;
        n.vec_fetch = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        ext_evt = '0;
        ext_lvl = '0;
        ent = '0;
        found = 1'b0;
        best = '0;

        // Pins are asynchronous; only the second and third stages are examined
        n.pin_s1 = i_ext_pin;
        n.pin_s2 = r.pin_s1;
        n.pin_q = r.pin_s2;
        n.motor_emergency_stop_s1 = i_motor_emergency_stop_pin;
        n.motor_emergency_stop_s2 = r.motor_emergency_stop_s1;
        n.motor_emergency_stop_q = r.motor_emergency_stop_s2;
        rise = r.pin_s2 & ~r.pin_q;
        fall = ~r.pin_s2 & r.pin_q;

        for (int p = 0; p < npic_pkg::NPIN; p++) begin
            g = npic_pkg::npic_grp(p);
            m = r.sens[2*g +: 2];
            if (r.pinsel[p]) begin
                if (m == npic_pkg::SENS_FALL_LOW) begin
                    ext_lvl[g] = ext_lvl[g] | ~r.pin_s2[p]; // RULE_13
                end else begin
                    ext_evt[g] = ext_evt[g] // RULE_15
                        | ((m != npic_pkg::SENS_FALL) & rise[p])
                        | ((m != npic_pkg::SENS_RISE) & fall[p]);
                end
            end
        end

        motor_emergency_stop_evt = r.sens[npic_pkg::SENS_MOTOR_EMERGENCY_STOP_EN] & (i_speed_err // RULE_12
            | (r.sens[npic_pkg::SENS_MOTOR_EMERGENCY_STOP_EDGE]
               ? (r.motor_emergency_stop_s2 & ~r.motor_emergency_stop_q) : (~r.motor_emergency_stop_s2 & r.motor_emergency_stop_q)));
        preq = i_periph_flag & i_periph_en & npic_pkg::PERIPH_MASK; // RULE_16

        if (r.state == npic_pkg::ST_VEC && !r.sel_trap) begin
            ent[r.sel] = 1'b1;
        end

        // New events win over a clear in the same cycle
        n.pend[npic_pkg::VEC_MOTOR_EMERGENCY_STOP] = motor_emergency_stop_evt
            | (r.pend[npic_pkg::VEC_MOTOR_EMERGENCY_STOP] & ~ent[npic_pkg::VEC_MOTOR_EMERGENCY_STOP]);
        for (int k = 0; k < npic_pkg::NGRP; k++) begin
            v = npic_pkg::VEC_EI0 + k;
            if (r.sens[2*k +: 2] == npic_pkg::SENS_FALL_LOW) begin
                n.pend[v] = ext_lvl[k];
            end else begin
                n.pend[v] = ext_evt[k] | (r.pend[v] & ~ent[v]); // RULE_14
            end
        end
        for (int k = 0; k < npic_pkg::NVEC; k++) begin
            if (npic_pkg::PERIPH_MASK[k]) begin
                n.pend[k] = preq[k] // RULE_17
                    | (r.pend[k] & ~i_periph_clr[k]); // RULE_22
            end
        end

        // Two-step arbitration; walking downward lets ties go low
        cur = npic_pkg::npic_lvl(r.prio);
        for (int k = npic_pkg::NVEC - 1; k >= 0; k--) begin
            lv = (k == npic_pkg::VEC_MOTOR_EMERGENCY_STOP) ? 3'h4 // RULE_06
                : npic_pkg::npic_lvl(r.ispr[2*k +: 2]);
            ok = r.pend[k] && (!i_halt || npic_pkg::HALT_CAP[k])
                && (k == npic_pkg::VEC_MOTOR_EMERGENCY_STOP || lv > cur); // RULE_11
            if (ok && (!found || lv >= best_lv)) begin // RULE_04
                found = 1'b1;
                best = k[3:0]; // RULE_19
                best_lv = lv;
            end
        end

        unique case (r.state)
            npic_pkg::ST_RSTV: begin
                n.vec_fetch = 1'b1;
                n.vec_addr = npic_pkg::VEC_RESET; // RULE_10
                n.prio = npic_pkg::PRIO_L3;
                n.state = npic_pkg::ST_IDLE;
            end
            npic_pkg::ST_IDLE: begin
                if (i_return_from_interrupt) begin
                    n.prio = i_pop_prio; // RULE_03
                end else if (i_prio_wr) begin
                    n.prio = i_prio_wdata; // RULE_01
                end
                if (i_instr_done && (i_trap || found)) begin // RULE_05
                    n.state = npic_pkg::ST_STACK;
                    n.cnt = npic_pkg::STK_PCL;
                    n.sel_trap = i_trap;
                    n.sel = best;
                    if (i_trap || best == npic_pkg::VEC_MOTOR_EMERGENCY_STOP) begin
                        n.new_prio = npic_pkg::PRIO_L3; // RULE_07
                    end else begin
                        n.new_prio = r.ispr[2*best +: 2];
                    end
                    n.vec_addr = i_trap ? npic_pkg::VEC_TRAP // RULE_09
                        : npic_pkg::VEC_BASE - {11'h000, best, 1'b0}; // RULE_18
                end
            end
            npic_pkg::ST_STACK: begin
                n.push = 1'b1;
                n.push_item = r.cnt; // RULE_02
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == npic_pkg::STK_LAST) begin
                    n.state = npic_pkg::ST_VEC;
                end
            end
            npic_pkg::ST_VEC: begin
                n.vec_fetch = 1'b1;
                n.prio = r.new_prio; // RULE_02
                n.state = npic_pkg::ST_IDLE;
            end
        endcase

        n.wake_wait = |n.pend; // RULE_21
        n.wake_halt = (|(n.pend & npic_pkg::HALT_CAP)) | i_trap; // RULE_08

        // APB: answer one cycle into the access phase
        wr_ok = i_psel && i_penable && i_pwrite && r.pready;
        if (i_psel && i_penable && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = '0;
            unique case (i_paddr)
                npic_pkg::ADDR_ISPR0: n.prdata[7:0] = r.ispr[7:0];
                npic_pkg::ADDR_ISPR1: n.prdata[7:0] = r.ispr[15:8];
                npic_pkg::ADDR_ISPR2: n.prdata[7:0] = r.ispr[23:16];
                npic_pkg::ADDR_ISPR3: n.prdata[7:0] = r.ispr[31:24];
                npic_pkg::ADDR_SENS: n.prdata[7:0] = r.sens;
                npic_pkg::ADDR_PINSEL: n.prdata[15:0] = r.pinsel;
                npic_pkg::ADDR_STATUS: n.prdata = {12'h000, r.state,
                    r.prio, 2'b00, r.pend};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (wr_ok) begin
            if (i_paddr[7:4] == 4'h0 && i_paddr[1:0] == 2'b00) begin
                idx = int'(i_paddr[3:2]);
                for (int k = 0; k < 4; k++) begin
                    v = 4 * idx + k;
                    f = i_pwdata[2*k +: 2];
                    // Upper nibble of the last register stays read-only
                    if (v < npic_pkg::NVEC && f != npic_pkg::PRIO_L0) begin
                        n.ispr[2*v +: 2] = f; // RULE_20
                    end
                end
            end else if (i_paddr == npic_pkg::ADDR_SENS) begin
                n.sens = i_pwdata[7:0];
            end else if (i_paddr == npic_pkg::ADDR_PINSEL) begin
                n.pinsel = i_pwdata[15:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= npic_pkg::npic_reset(); // RULE_22
        end else begin
            r <= n;
        end
    end

    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_push = r.push;
    assign o_push_item = r.push_item;
    assign o_vec_fetch = r.vec_fetch;
    assign o_vec_addr = r.vec_addr;
    assign o_prio = r.prio;
    assign o_wake_halt = r.wake_halt;
    assign o_wake_wait = r.wake_wait;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_stack5;
        o_push[*5];
    endsequence
    sequence s_fetch;
        o_vec_fetch && !o_push;
    endsequence

    property p_rst_vec;
        $fell(i_rst) |=> o_vec_fetch && o_vec_addr == npic_pkg::VEC_RESET
            && o_prio == npic_pkg::PRIO_L3;
    endproperty
    a_rst_vec: assert property (p_rst_vec) // RULE_10
        else $error("reset vector not fetched at level 3");

    property p_stack_seq;
        $rose(o_push) |-> o_push_item == npic_pkg::STK_PCL
            ##0 s_stack5 ##1 s_fetch;
    endproperty
    a_stack_seq: assert property (p_stack_seq) // RULE_02
        else $error("stacking sequence wrong");

    property p_trap_l3;
        o_vec_fetch && o_vec_addr == npic_pkg::VEC_TRAP
            |-> o_prio == npic_pkg::PRIO_L3;
    endproperty
    a_trap_l3: assert property (p_trap_l3) // RULE_09
        else $error("trap entry not at level 3");

    property p_motor_emergency_stop_l3;
        o_vec_fetch && o_vec_addr == npic_pkg::VEC_BASE
            |-> o_prio == npic_pkg::PRIO_L3;
    endproperty
    a_motor_emergency_stop_l3: assert property (p_motor_emergency_stop_l3) // RULE_07
        else $error("emergency stop entry not at level 3");

    property p_return_from_interrupt;
        r.state == npic_pkg::ST_IDLE && i_return_from_interrupt
            |=> o_prio == $past(i_pop_prio);
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) // RULE_03
        else $error("return did not restore priority");

    property p_l0_ignored;
        wr_ok && i_paddr == npic_pkg::ADDR_ISPR0
            && i_pwdata[1:0] == npic_pkg::PRIO_L0
            |=> r.ispr[1:0] == $past(r.ispr[1:0]);
    endproperty
    a_l0_ignored: assert property (p_l0_ignored) // RULE_20
        else $error("level 0 write changed a priority field");

    property p_eligible;
        r.state == npic_pkg::ST_IDLE && n.state == npic_pkg::ST_STACK
            && !i_trap && best != 4'(npic_pkg::VEC_MOTOR_EMERGENCY_STOP)
            |-> npic_pkg::npic_lvl(r.ispr[2*best +: 2])
                > npic_pkg::npic_lvl(r.prio);
    endproperty
    a_eligible: assert property (p_eligible) // RULE_11
        else $error("masked request was serviced");

    property p_edge_clr;
        r.state == npic_pkg::ST_VEC && !r.sel_trap
            && r.sel == 4'(npic_pkg::VEC_EI0)
            && r.sens[1:0] != npic_pkg::SENS_FALL_LOW && !ext_evt[0]
            |=> !r.pend[npic_pkg::VEC_EI0] ##5 !o_push;
    endproperty
    a_edge_clr: assert property (p_edge_clr) // RULE_14
        else $error("edge latch not cleared on entry");

    property p_pend_hold;
        r.pend[5] && !i_periph_clr[5] |=> r.pend[5];
    endproperty
    a_pend_hold: assert property (p_pend_hold) // RULE_05
        else $error("pending request lost");

    property p_wake;
        (|(r.pend & npic_pkg::HALT_CAP)) |-> o_wake_halt && o_wake_wait;
    endproperty
    a_wake: assert property (p_wake) // RULE_13
        else $error("pending source did not request wake");

endmodule : npic_top

/* File: npic_pkg.sv */
/*
 * Constants, state types and helper functions for the nested priority
 * interrupt controller.
 * Assumes a single CPU clock domain and an APB register slave with an
 * 8-bit byte address.
 */
package npic_pkg;

    localparam int NVEC = 14;
    localparam int NPIN = 16;
    localparam int GRP1_FIRST = 8;
    localparam int GRP2_FIRST = 12;

    // Vector indices, lowest index has the highest hardware priority
    localparam int VEC_MOTOR_EMERGENCY_STOP = 0;
    localparam int VEC_EI0 = 2;
    localparam int NGRP = 3;

    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_BASE = 16'hfffa;

    // Current priority encodings, high bit then low bit
    localparam logic [1:0] PRIO_L0 = 2'b10;
    localparam logic [1:0] PRIO_L1 = 2'b01;
    localparam logic [1:0] PRIO_L2 = 2'b00;
    localparam logic [1:0] PRIO_L3 = 2'b11;

    localparam logic [13:0] PERIPH_MASK = 14'h3fe2;
    localparam logic [13:0] HALT_CAP = 14'h3fde;

    // Stacking order
    localparam logic [2:0] STK_PCL = 3'h0;
    localparam logic [2:0] STK_PCH = 3'h1;
    localparam logic [2:0] STK_X = 3'h2;
    localparam logic [2:0] STK_A = 3'h3;
    localparam logic [2:0] STK_CC = 3'h4;
    localparam logic [2:0] STK_LAST = STK_CC;

    // Register byte addresses
    localparam logic [7:0] ADDR_ISPR0 = 8'h00;
    localparam logic [7:0] ADDR_ISPR1 = 8'h04;
    localparam logic [7:0] ADDR_ISPR2 = 8'h08;
    localparam logic [7:0] ADDR_ISPR3 = 8'h0c;
    localparam logic [7:0] ADDR_SENS = 8'h10;
    localparam logic [7:0] ADDR_PINSEL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    localparam logic [31:0] ISPR_RST = 32'hffffffff;
    localparam logic [7:0] SENS_RST = 8'h00;
    localparam logic [15:0] PINSEL_RST = 16'h0000;

    // Sensitivity control fields
    localparam int SENS_MOTOR_EMERGENCY_STOP_EDGE = 6;
    localparam int SENS_MOTOR_EMERGENCY_STOP_EN = 7;
    localparam logic [1:0] SENS_FALL_LOW = 2'b00;
    localparam logic [1:0] SENS_RISE = 2'b01;
    localparam logic [1:0] SENS_FALL = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STACK = 2'b01,
        ST_VEC = 2'b11,
        ST_RSTV = 2'b10
    } npic_state_t;

    typedef struct packed {
        npic_state_t state;
        logic [2:0] cnt;
        logic [31:0] ispr;
        logic [7:0] sens;
        logic [15:0] pinsel;
        logic [NVEC-1:0] pend;
        logic [1:0] prio;
        logic [1:0] new_prio;
        logic [3:0] sel;
        logic sel_trap;
        logic [15:0] vec_addr;
        logic push;
        logic [2:0] push_item;
        logic vec_fetch;
        logic wake_halt;
        logic wake_wait;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic [15:0] pin_q;
        logic motor_emergency_stop_s1;
        logic motor_emergency_stop_s2;
        logic motor_emergency_stop_q;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } npic_regs_t;

    function automatic logic [2:0] npic_lvl(input logic [1:0] b);
        case (b)
            PRIO_L0: npic_lvl = 3'h0;
            PRIO_L1: npic_lvl = 3'h1;
            PRIO_L2: npic_lvl = 3'h2;
            default: npic_lvl = 3'h3;
        endcase
    endfunction : npic_lvl

    function automatic int npic_grp(input int p);
        if (p < GRP1_FIRST) begin
            return 0;
        end else if (p < GRP2_FIRST) begin
            return 1;
        end
        return 2;
    endfunction : npic_grp

    function automatic npic_regs_t npic_reset();
        npic_regs_t v;
        v = '0;
        v.state = ST_RSTV;
        v.ispr = ISPR_RST;
        v.sens = SENS_RST;
        v.pinsel = PINSEL_RST;
        v.prio = PRIO_L3;
        v.new_prio = PRIO_L3;
        v.vec_addr = VEC_RESET;
        return v;
    endfunction : npic_reset

endpackage : npic_pkg

/* File: npic_core_model.sv */
/*
 * Core-side partner for the interrupt controller: marks instruction
 * boundaries, issues traps and checks each stacking sequence.
 * Assumes the controller's clock and synchronous active-high reset.
 */
module npic_core_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_trap_req,
    input wire logic i_push,
    input wire logic [2:0] i_push_item,
    input wire logic i_vec_fetch,
    output logic o_instr_done,
    output logic o_trap,
    output logic o_seq_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r;
    logic booted_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_instr_done <= 1'b0;
            o_trap <= 1'b0;
            o_seq_err <= 1'b0;
            cnt_r <= 3'h0;
            booted_r <= 1'b0;
        end else begin
            // A trap always comes with a boundary
            o_instr_done <= i_run | i_trap_req;
            o_trap <= i_trap_req;
            if (i_push) begin
                if (i_push_item !== cnt_r) begin
                    o_seq_err <= 1'b1;
                end
                cnt_r <= cnt_r + 3'h1;
            end
            if (i_vec_fetch) begin
                // Reset fetch comes without stacking
                if (cnt_r !== (booted_r ? 3'h5 : 3'h0)) begin
                    o_seq_err <= 1'b1;
                end
                cnt_r <= 3'h0;
                booted_r <= 1'b1;
            end
        end
    end
endmodule : npic_core_model

/* File: npic_top_test.sv */
/*
 * Self-checking bench for the interrupt controller: APB tasks, a core
 * model, peripheral flags and external pins driven from here.
 * Assumes one-wait-state APB answers and the documented fetch timing.
 */
module npic_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, penable, pwrite, run, trap_req, return_from_interrupt, prio_wr;
    logic speed_err, pready, pslverr, push, vec_fetch, wake_halt;
    logic wake_wait, instr_done, trap, seq_err, e, halt, motor_emergency_stop;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] pop_prio, prio_wdata, prio;
    logic [15:0] ext_pin, vec_addr;
    logic [13:0] pflag, pen, pclr;
    logic [2:0] push_item;
    int num_errors, comparisons, n;

    npic_top i_npic_top (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_instr_done(instr_done), .i_trap(trap),
        .i_return_from_interrupt(return_from_interrupt), .i_pop_prio(pop_prio), .i_prio_wr(prio_wr),
        .i_prio_wdata(prio_wdata), .i_halt(halt), .i_ext_pin(ext_pin),
        .i_motor_emergency_stop_pin(motor_emergency_stop), .i_speed_err(speed_err),
        .i_periph_flag(pflag), .i_periph_en(pen), .i_periph_clr(pclr),
        .o_push(push), .o_push_item(push_item), .o_vec_fetch(vec_fetch),
        .o_vec_addr(vec_addr), .o_prio(prio), .o_wake_halt(wake_halt),
        .o_wake_wait(wake_wait));

    npic_core_model i_npic_core_model (.i_ref_clk(clk), .i_rst(rst),
        .i_run(run), .i_trap_req(trap_req), .i_push(push),
        .i_push_item(push_item), .i_vec_fetch(vec_fetch),
        .o_instr_done(instr_done), .o_trap(trap), .o_seq_err(seq_err));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic hang();
        num_errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        end_of_test();
    endtask : hang

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            hang();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wfetch(input logic [15:0] a, input logic [1:0] p);
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (vec_fetch === 1'b1) break;
        end
        if (k == 40) begin
            hang();
        end
        chk(vec_addr, a);
        chk(prio, p);
    endtask : wfetch

    task automatic setp(input logic [1:0] p);
        prio_wdata <= p;
        prio_wr <= 1'b1;
        @(posedge clk);
        prio_wr <= 1'b0;
        @(posedge clk);
    endtask : setp

    initial begin
        {rst, psel, penable, pwrite, run, trap_req, return_from_interrupt} = 7'h40;
        {prio_wr, speed_err, paddr, pwdata} = '0;
        {pop_prio, prio_wdata, ext_pin, pflag, pen, pclr} = '0;
        {halt, motor_emergency_stop} = '0;
        num_errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wfetch(16'hfffe, 2'b11);
        run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(q, 32'hff);
        end
        apb(1'b1, npic_pkg::ADDR_ISPR0, 32'hcf);
        apb(1'b1, npic_pkg::ADDR_ISPR0, 32'h64);
        apb(1'b0, npic_pkg::ADDR_ISPR0, 32'h0);
        chk(q, 32'h44);
        apb(1'b1, npic_pkg::ADDR_ISPR3, 32'h0);
        apb(1'b0, npic_pkg::ADDR_ISPR3, 32'h0);
        chk(q, 32'hf0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // Vector 6 at level 1, vector 7 at level 2
        apb(1'b1, npic_pkg::ADDR_ISPR1, 32'h1f);
        setp(2'b10);
        chk(prio, 2'b10);
        pen <= 14'h00c0;
        pflag <= 14'h00c0;
        wfetch(16'hffec, 2'b00);
        pflag <= 14'h0040;
        pclr <= 14'h0080;
        @(posedge clk);
        pclr <= 14'h0;
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[17:0] & 18'h300c0, 32'h40);
        pop_prio <= 2'b10;
        return_from_interrupt <= 1'b1;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
        @(posedge clk);
        chk(prio, 2'b10);
        wfetch(16'hffee, 2'b01);
        pflag <= 14'h0;
        pclr <= 14'h0040;
        @(posedge clk);
        pclr <= 14'h0;
        setp(2'b11);
        pflag <= 14'h0100;
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[13:0], 32'h0);
        pen <= 14'h0100;
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[13:0], 32'h100);
        chk({wake_halt, wake_wait}, 32'h3);
        pflag <= 14'h0;
        pclr <= 14'h0100;
        @(posedge clk);
        pclr <= 14'h0;
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[13:0], 32'h0);
        trap_req <= 1'b1;
        @(posedge clk);
        trap_req <= 1'b0;
        wfetch(16'hfffc, 2'b11);
        // Stop enabled, line 0 on rising edges
        apb(1'b1, npic_pkg::ADDR_SENS, 32'h81);
        speed_err <= 1'b1;
        @(posedge clk);
        speed_err <= 1'b0;
        wfetch(16'hfffa, 2'b11);
        apb(1'b1, npic_pkg::ADDR_PINSEL, 32'h3);
        ext_pin <= 16'h0002;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wake_halt === 1'b1) break;
        end
        chk(n < 20, 32'h1);
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[13:0], 32'h4);
        setp(2'b10);
        wfetch(16'hfff6, 2'b00);
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[13:0], 32'h0);
        // Stop pin set to falling edges by the earlier write
        motor_emergency_stop <= 1'b1;
        repeat (5) @(posedge clk);
        motor_emergency_stop <= 1'b0;
        wfetch(16'hfffa, 2'b11);
        // Vector 5 cannot leave halt, so it must wait
        halt <= 1'b1;
        pen <= 14'h0020;
        pflag <= 14'h0020;
        setp(2'b10);
        apb(1'b0, npic_pkg::ADDR_STATUS, 32'h0);
        chk(q[17:0] & 18'h30020, 32'h20020);
        chk({wake_halt, wake_wait}, 32'h1);
        halt <= 1'b0;
        wfetch(16'hfff0, 2'b11);
        pflag <= 14'h0;
        pclr <= 14'h0020;
        @(posedge clk);
        pclr <= 14'h0;
        chk(seq_err, 32'h0);
        end_of_test();
    end
endmodule : npic_top_test
